// ### inc/sci_regs.vh
/*
 * Register indices, field positions, reset values and codes of the
 * socket command and event block. Assumes byte address = 4 * index.
 */
`ifndef SCI_REGS_VH
`define SCI_REGS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SCI_IDX_MODE 24'hfe_4000
`define SCI_IDX_CMD 24'hfe_4001
`define SCI_IDX_FLAGS 24'hfe_4002
`define SCI_IDX_STATE 24'hfe_4003
`define SCI_IDX_RXRD 24'hfe_4028
`define SCI_IDX_MASK 24'hfe_402c
`define SCI_IDX_GFLAGS 24'hfe_0015
`define SCI_IDX_GMASK 24'hfe_0016

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SCI_RST_FLAGS 8'h00
`define SCI_RST_MASK 8'hff
`define SCI_RST_GMASK 8'h00

// ----------------------------------------------------------------
// Event flag bit positions
// ----------------------------------------------------------------
`define SCI_EV_CON 0
`define SCI_EV_DISCONNECT_CMD 1
`define SCI_EV_RECEIVE_CMD 2
`define SCI_EV_TIMEOUT 3
`define SCI_EV_SENDOK 4
`define SCI_EV_PPHASE 5
`define SCI_EV_PPP_AUTH_FAIL_FLAG 6
`define SCI_EV_POPT 7

// ----------------------------------------------------------------
// Protocol select codes
// ----------------------------------------------------------------
`define SCI_MODE_TCP 4'h1
`define SCI_MODE_UDP 4'h2
`define SCI_MODE_PPPOE 4'h5

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define SCI_CMD_OPEN 8'h01
`define SCI_CMD_LISTEN 8'h02
`define SCI_CMD_CONNECT 8'h04
`define SCI_CMD_DISCONNECT_CMD 8'h08
`define SCI_CMD_CLOSE 8'h10
`define SCI_CMD_SEND 8'h20
`define SCI_CMD_SEND_RAW 8'h21
`define SCI_CMD_KEEP 8'h22
`define SCI_CMD_PPP_LINK_OPEN 8'h23
`define SCI_CMD_PPP_LINK_CLOSE 8'h24
`define SCI_CMD_PREQ 8'h25
`define SCI_CMD_PNAK 8'h26
`define SCI_CMD_PREJ 8'h27
`define SCI_CMD_RECEIVE_CMD 8'h40

// ----------------------------------------------------------------
// Decoded action bit positions
// ----------------------------------------------------------------
`define SCI_ACT_W 14
`define SCI_A_OPEN 0
`define SCI_A_LISTEN 1
`define SCI_A_CONNECT 2
`define SCI_A_DISCONNECT_CMD 3
`define SCI_A_CLOSE 4
`define SCI_A_SEND 5
`define SCI_A_SEND_RAW 6
`define SCI_A_KEEP 7
`define SCI_A_RECEIVE_CMD 8
`define SCI_A_PPP_LINK_OPEN 9
`define SCI_A_PDIS 10
`define SCI_A_PREQ 11
`define SCI_A_PNAK 12
`define SCI_A_PREJ 13

// ----------------------------------------------------------------
// Socket state codes
// ----------------------------------------------------------------
`define SCI_ST_CLOSED 8'h00
`define SCI_ST_INIT 8'h13
`define SCI_ST_LISTEN 8'h14
`define SCI_ST_SYNSENT 8'h15
`define SCI_ST_CONNECTED 8'h17
`define SCI_ST_FINWAIT 8'h18
`define SCI_ST_CLOSE_WAIT 8'h1c
`define SCI_ST_LASTACK 8'h1d
`define SCI_ST_UDP 8'h22
`define SCI_ST_PPPOE 8'h5f

`endif

// ### src/sci_cmd_dec.v
/*
 * Command decoder: turns a command code into one action bit, checked
 * against protocol and socket state. Assumes a single socket 0.
 */
`include "sci_regs.vh"
`default_nettype none

module sci_cmd_dec (
  // Command and context
  input wire [7:0] i_code,
  input wire [3:0] i_mode,
  input wire [7:0] i_state,
  // Decoded action
  output reg [`SCI_ACT_W-1:0] o_act
);

  wire tcp;
  wire udp;
  wire ppp;
  assign tcp = (i_mode == `SCI_MODE_TCP);
  assign udp = (i_mode == `SCI_MODE_UDP);
  assign ppp = (i_mode == `SCI_MODE_PPPOE);

  always @* begin
    o_act = {`SCI_ACT_W{1'b0}};
    case (i_code)
      `SCI_CMD_OPEN: o_act[`SCI_A_OPEN] = 1'b1;
      `SCI_CMD_LISTEN: o_act[`SCI_A_LISTEN] = tcp;
      `SCI_CMD_CONNECT: o_act[`SCI_A_CONNECT] = tcp;
      `SCI_CMD_DISCONNECT_CMD: o_act[`SCI_A_DISCONNECT_CMD] = tcp;
      `SCI_CMD_CLOSE: o_act[`SCI_A_CLOSE] = 1'b1;
      `SCI_CMD_SEND: o_act[`SCI_A_SEND] = 1'b1;
      `SCI_CMD_SEND_RAW: o_act[`SCI_A_SEND_RAW] = udp;
      `SCI_CMD_KEEP: o_act[`SCI_A_KEEP] = tcp &&
        (i_state == `SCI_ST_CONNECTED);
      `SCI_CMD_RECEIVE_CMD: o_act[`SCI_A_RECEIVE_CMD] = 1'b1;
      `SCI_CMD_PPP_LINK_OPEN: o_act[`SCI_A_PPP_LINK_OPEN] = ppp;
      `SCI_CMD_PPP_LINK_CLOSE: o_act[`SCI_A_PDIS] = ppp;
      `SCI_CMD_PREQ: o_act[`SCI_A_PREQ] = ppp;
      `SCI_CMD_PNAK: o_act[`SCI_A_PNAK] = ppp;
      `SCI_CMD_PREJ: o_act[`SCI_A_PREJ] = ppp;
      default: o_act = {`SCI_ACT_W{1'b0}};
    endcase
  end

endmodule // sci_cmd_dec
`default_nettype wire

// ### src/sci_w1c_flags.v
/*
 * Masked event flags, cleared by writing one. A set in the same cycle
 * as a clear wins. Assumes events and clears on the same clock.
 */
`include "sci_regs.vh"
`default_nettype none

module sci_w1c_flags (
  // Clock and reset
  input wire i_clk,
  input wire i_srst,
  // Events and software clear
  input wire [7:0] i_event,
  input wire [7:0] i_mask,
  input wire i_clr_we,
  input wire [7:0] i_clr_data,
  // Flags
  output wire [7:0] o_flags
);

  reg [7:0] flags_q;
  wire [7:0] set;
  wire [7:0] clr;

  assign set = i_event & i_mask;
  assign clr = i_clr_we ? i_clr_data : 8'h00;
  assign o_flags = flags_q;

  always @(posedge i_clk) begin
    if (i_srst) begin
      flags_q <= `SCI_RST_FLAGS;
    end else begin
      flags_q <= (flags_q & ~clr) | set;
    end
  end

endmodule // sci_w1c_flags
`default_nettype wire

// ### src/sci_socket.v
/*
 * Socket 0 command interpreter with event flags, global socket flag
 * and active-low interrupt, reached over an Avalon-MM slave with
 * waitrequest. Assumes the packet engine runs on the same clock and
 * gives one-cycle event pulses; the PPPoE commands need socket 0.
 */
`include "sci_regs.vh"
`default_nettype none

// Function
// - Successful connect moves state to connected and sets flag bit 0.
// - Connect fails to closed on resolution timeout, TCP timeout or reset.
// - Disconnect 0x08, TCP only, sends FIN actively or answers peer FIN.
// - After disconnect, FIN/ACK or timeout (bit 3) closes the socket.
// - A reset from the peer closes the socket in TCP mode only.
// - Send 0x20 transmits all untransmitted data in transmit memory.
// - Send 0x21, UDP only, uses software hardware address, no resolution.
// - Keepalive 0x22 in TCP, connected state only, sends a probe; failure raises timeout.
// - Receive 0x40 consumes data up to the receive read pointer.
// - PPPoE link open 0x23 and close 0x24 only on socket 0.
// - PPP codes 0x25, 0x26, 0x27 send request, nak, reject.
// - An event flag is set only while its mask bit is one.
// - Writing one clears a flag; software writes ones only to clear.
// - All flags cleared clears the socket's global flag bit.
// - Mask and flag set the global bit; global mask drives interrupt.
// - Transmit-done flag bit 4 sets when a send completes.
// - Timeout flag bit 3 sets on resolution or TCP timeout.
// - Receive flag bit 2 sets on every arriving data packet.
// - Disconnect flag bit 1 sets on FIN or FIN/ACK received.
// - Connected flag bit 0 sets once on entry to connected.
// - PPPoE sets bit 7 bad option, bit 6 auth fail, bit 5 phase.
// - Closed is 0x00, connected 0x17; close paths force closed.
module sci_socket (
  // Clock and reset
  input wire i_clk,
  input wire i_srst,
  // Avalon-MM slave
  input wire [25:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  // Events from packet engine
  input wire i_ev_synack,
  input wire i_ev_rst,
  input wire i_ev_fin,
  input wire i_ev_finack,
  input wire i_ev_arp_to,
  input wire i_ev_tcp_to,
  input wire i_ev_ka_fail,
  input wire i_ev_data_rx,
  input wire i_ev_send_done,
  input wire i_ev_ppp_opt,
  input wire i_ev_ppp_auth_fail,
  input wire i_ev_ppp_phase,
  // Requests to packet engine
  output reg o_tx_syn,
  output reg o_tx_fin,
  output reg o_tx_send,
  output reg o_tx_raw_dest,
  output reg o_tx_keepalive,
  output reg o_rx_consume,
  output reg [15:0] o_rx_read_ptr,
  output reg o_ppp_link_open,
  output reg o_ppp_link_close,
  output reg o_ppp_msg,
  output reg [1:0] o_ppp_msg_kind,
  // Status and interrupt
  output reg [7:0] o_socket_state,
  output reg o_net_irq_n
);

  // ----------------------------------------------------------------
  // Command engine states
  // ----------------------------------------------------------------
  localparam [1:0] CE_IDLE = 2'b01;
  localparam [1:0] CE_SEND = 2'b10;

  reg [1:0] ce_q;
  reg [1:0] ce_d;
  reg [3:0] mode_q;
  reg [7:0] mask_q;
  reg [7:0] gmask_q;
  reg [7:0] cmd_q;
  reg cmd_pend_q;
  reg [7:0] state_d;
  reg [7:0] ev;
  wire [7:0] flags;
  wire [`SCI_ACT_W-1:0] act;
  wire [`SCI_ACT_W-1:0] act_go;
  wire gflag;
  wire take;
  wire wr_en;
  wire [23:0] idx;
  wire aligned;
  wire tcp;
  wire ppp;

  // ----------------------------------------------------------------
  // Bus decode: one wait cycle, then accept
  // ----------------------------------------------------------------
  assign take = (i_avs_read || i_avs_write) && !o_avs_waitrequest;
  assign wr_en = take && i_avs_write;
  assign idx = i_avs_address[25:2];
  assign aligned = (i_avs_address[1:0] == 2'b00);
  assign tcp = (mode_q == `SCI_MODE_TCP);
  assign ppp = (mode_q == `SCI_MODE_PPPOE);

  always @(posedge i_clk) begin
    if (i_srst) begin
      o_avs_waitrequest <= 1'b1;
    end else if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
      o_avs_waitrequest <= 1'b0;
    end else begin
      o_avs_waitrequest <= 1'b1;
    end
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && o_avs_waitrequest) begin
      o_avs_readdata <= 32'h0000_0000;
      if (aligned) begin
        case (idx)
          `SCI_IDX_MODE: o_avs_readdata[3:0] <= mode_q;
          `SCI_IDX_CMD: o_avs_readdata[7:0] <= cmd_pend_q ? cmd_q : 8'h00;
          `SCI_IDX_FLAGS: o_avs_readdata[7:0] <= flags;
          `SCI_IDX_STATE: o_avs_readdata[7:0] <= o_socket_state;
          `SCI_IDX_RXRD: o_avs_readdata[15:0] <= o_rx_read_ptr;
          `SCI_IDX_MASK: o_avs_readdata[7:0] <= mask_q;
          `SCI_IDX_GFLAGS: o_avs_readdata[7:0] <= {7'h00, gflag};
          `SCI_IDX_GMASK: o_avs_readdata[7:0] <= gmask_q;
          default: o_avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_srst) begin
      mode_q <= 4'h0;
      mask_q <= `SCI_RST_MASK;
      gmask_q <= `SCI_RST_GMASK;
      o_rx_read_ptr <= 16'h0000;
      cmd_q <= 8'h00;
      cmd_pend_q <= 1'b0;
    end else begin
      if (wr_en && aligned && idx == `SCI_IDX_MODE) begin
        mode_q <= i_avs_writedata[3:0];
      end
      if (wr_en && aligned && idx == `SCI_IDX_MASK) begin
        mask_q <= i_avs_writedata[7:0];
      end
      if (wr_en && aligned && idx == `SCI_IDX_GMASK) begin
        gmask_q <= i_avs_writedata[7:0];
      end
      if (wr_en && aligned && idx == `SCI_IDX_RXRD) begin
        o_rx_read_ptr <= i_avs_writedata[15:0];
      end
      if (wr_en && aligned && idx == `SCI_IDX_CMD) begin
        cmd_q <= i_avs_writedata[7:0];
        cmd_pend_q <= 1'b1;
      end else if (ce_q == CE_IDLE) begin
        cmd_pend_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  sci_cmd_dec u_dec (
    .i_code(cmd_q),
    .i_mode(mode_q),
    .i_state(o_socket_state),
    .o_act(act)
  );

  assign act_go = (cmd_pend_q && ce_q == CE_IDLE) ? act :
    {`SCI_ACT_W{1'b0}};

  // ----------------------------------------------------------------
  // Socket state and command engine
  // ----------------------------------------------------------------
  always @* begin
    state_d = o_socket_state;
    ce_d = ce_q;
    case (ce_q)
      CE_IDLE: begin
        if (act_go[`SCI_A_SEND] || act_go[`SCI_A_SEND_RAW]) begin
          ce_d = CE_SEND;
        end
      end
      CE_SEND: begin
        if (i_ev_send_done) begin
          ce_d = CE_IDLE;
        end
      end
      default: ce_d = CE_IDLE;
    endcase
    if (act_go[`SCI_A_OPEN]) begin
      case (mode_q)
        `SCI_MODE_TCP: state_d = `SCI_ST_INIT;
        `SCI_MODE_UDP: state_d = `SCI_ST_UDP;
        `SCI_MODE_PPPOE: state_d = `SCI_ST_PPPOE;
        default: state_d = `SCI_ST_CLOSED;
      endcase
    end
    if (act_go[`SCI_A_LISTEN] && o_socket_state == `SCI_ST_INIT) begin
      state_d = `SCI_ST_LISTEN;
    end
    if (act_go[`SCI_A_CONNECT] && o_socket_state == `SCI_ST_INIT) begin
      state_d = `SCI_ST_SYNSENT;
    end
    if (act_go[`SCI_A_DISCONNECT_CMD]) begin
      if (o_socket_state == `SCI_ST_CONNECTED) begin
        state_d = `SCI_ST_FINWAIT;
      end else if (o_socket_state == `SCI_ST_CLOSE_WAIT) begin
        state_d = `SCI_ST_LASTACK;
      end else begin
        state_d = `SCI_ST_CLOSED;
      end
    end
    if (i_ev_synack && (o_socket_state == `SCI_ST_SYNSENT ||
        o_socket_state == `SCI_ST_LISTEN)) begin
      state_d = `SCI_ST_CONNECTED;
    end
    if (i_ev_fin && o_socket_state == `SCI_ST_CONNECTED) begin
      state_d = `SCI_ST_CLOSE_WAIT;
    end
    if (i_ev_finack && (o_socket_state == `SCI_ST_FINWAIT ||
        o_socket_state == `SCI_ST_LASTACK)) begin
      state_d = `SCI_ST_CLOSED;
    end
    if (tcp && (i_ev_arp_to || i_ev_tcp_to)) begin
      state_d = `SCI_ST_CLOSED;
    end
    if (tcp && i_ev_rst) begin
      state_d = `SCI_ST_CLOSED;
    end
    if (act_go[`SCI_A_CLOSE]) begin
      state_d = `SCI_ST_CLOSED;
      ce_d = CE_IDLE;
    end
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      ce_q <= CE_IDLE;
      o_socket_state <= `SCI_ST_CLOSED;
    end else begin
      ce_q <= ce_d;
      o_socket_state <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Requests to the packet engine
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_tx_syn <= 1'b0;
      o_tx_fin <= 1'b0;
      o_tx_send <= 1'b0;
      o_tx_raw_dest <= 1'b0;
      o_tx_keepalive <= 1'b0;
      o_rx_consume <= 1'b0;
      o_ppp_link_open <= 1'b0;
      o_ppp_link_close <= 1'b0;
      o_ppp_msg <= 1'b0;
      o_ppp_msg_kind <= 2'b00;
    end else begin
      o_tx_syn <= act_go[`SCI_A_CONNECT] &&
        o_socket_state == `SCI_ST_INIT;
      o_tx_fin <= act_go[`SCI_A_DISCONNECT_CMD] &&
        (o_socket_state == `SCI_ST_CONNECTED ||
        o_socket_state == `SCI_ST_CLOSE_WAIT);
      o_tx_send <= act_go[`SCI_A_SEND] || act_go[`SCI_A_SEND_RAW];
      o_tx_raw_dest <= act_go[`SCI_A_SEND_RAW];
      o_tx_keepalive <= act_go[`SCI_A_KEEP];
      o_rx_consume <= act_go[`SCI_A_RECEIVE_CMD];
      o_ppp_link_open <= act_go[`SCI_A_PPP_LINK_OPEN];
      o_ppp_link_close <= act_go[`SCI_A_PDIS];
      o_ppp_msg <= act_go[`SCI_A_PREQ] || act_go[`SCI_A_PNAK] ||
        act_go[`SCI_A_PREJ];
      if (act_go[`SCI_A_PREQ]) begin
        o_ppp_msg_kind <= 2'b00;
      end else if (act_go[`SCI_A_PNAK]) begin
        o_ppp_msg_kind <= 2'b01;
      end else if (act_go[`SCI_A_PREJ]) begin
        o_ppp_msg_kind <= 2'b10;
      end
    end
  end

  // ----------------------------------------------------------------
  // Event collection
  // ----------------------------------------------------------------
  always @* begin
    ev = 8'h00;
    ev[`SCI_EV_CON] = (state_d == `SCI_ST_CONNECTED) &&
      (o_socket_state != `SCI_ST_CONNECTED);
    ev[`SCI_EV_DISCONNECT_CMD] = i_ev_fin || i_ev_finack;
    ev[`SCI_EV_RECEIVE_CMD] = i_ev_data_rx;
    ev[`SCI_EV_TIMEOUT] = i_ev_arp_to || i_ev_tcp_to ||
      (i_ev_ka_fail && tcp);
    ev[`SCI_EV_SENDOK] = i_ev_send_done && ce_q == CE_SEND;
    ev[`SCI_EV_PPHASE] = i_ev_ppp_phase && ppp;
    ev[`SCI_EV_PPP_AUTH_FAIL_FLAG] = i_ev_ppp_auth_fail && ppp;
    ev[`SCI_EV_POPT] = i_ev_ppp_opt && ppp;
  end

  sci_w1c_flags u_flags (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_event(ev),
    .i_mask(mask_q),
    .i_clr_we(wr_en && aligned && idx == `SCI_IDX_FLAGS),
    .i_clr_data(i_avs_writedata[7:0]),
    .o_flags(flags)
  );

  // ----------------------------------------------------------------
  // Global socket flag and interrupt line
  // ----------------------------------------------------------------
  assign gflag = |(flags & mask_q);

  always @(posedge i_clk) begin
    if (i_srst) begin
      o_net_irq_n <= 1'b1;
    end else begin
      o_net_irq_n <= !(gflag && gmask_q[0]);
    end
  end

endmodule // sci_socket
`default_nettype wire

// ### verification/sci_socket_sva.sv
/* Checker of the socket command block, bound to sci_socket.
   Assumes one clock and a synchronous active-high reset. */
`include "sci_regs.vh"
`default_nettype none
module sci_socket_sva (
  // Clock and bus
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [25:0] i_avs_address,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic o_avs_waitrequest,
  // Events
  input wire logic i_ev_synack,
  input wire logic i_ev_rst,
  input wire logic i_ev_finack,
  input wire logic i_ev_arp_to,
  input wire logic i_ev_tcp_to,
  // Outputs
  input wire logic o_tx_fin,
  input wire logic o_tx_send,
  input wire logic o_tx_raw_dest,
  input wire logic o_tx_keepalive,
  input wire logic o_rx_consume,
  input wire logic o_ppp_msg,
  input wire logic [1:0] o_ppp_msg_kind,
  input wire logic [7:0] o_socket_state
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  // ----
  // Command accepted in a state
  // ----
  sequence s_cmd(logic [7:0] c);
    i_avs_write && !o_avs_waitrequest &&
    i_avs_address == {`SCI_IDX_CMD, 2'b00} && i_avs_writedata[7:0] == c;
  endsequence
  sequence s_cmd_in(logic [7:0] c, logic [7:0] s);
    s_cmd(c) ##0 o_socket_state == s;
  endsequence
  // ----
  // Checks
  // ----
  chk_close_now: assert property (s_cmd(`SCI_CMD_CLOSE)
    |-> ##[2:3] o_socket_state == `SCI_ST_CLOSED) else $error("close late");
  chk_disconnect_cmd_fin: assert property (s_cmd_in(8'h08, 8'h17)
    |-> ##[2:3] o_tx_fin) else $error("no fin");
  chk_send_go: assert property (s_cmd_in(8'h20, 8'h17)
    |-> ##[2:3] o_tx_send) else $error("no send");
  chk_raw_pair: assert property (o_tx_raw_dest |-> o_tx_send)
    else $error("raw alone");
  chk_ka_probe: assert property (s_cmd_in(8'h22, 8'h17)
    |-> ##[2:3] o_tx_keepalive) else $error("no probe");
  chk_receive_cmd_go: assert property (s_cmd_in(8'h40, 8'h17)
    |-> ##[2:3] o_rx_consume) else $error("no consume");
  chk_ppp_nak: assert property (s_cmd_in(8'h26, 8'h5f)
    |-> ##[2:3] o_ppp_msg && o_ppp_msg_kind == 2'd1) else $error("no nak");
  chk_peer_rst: assert property (i_ev_rst && o_socket_state == 8'h17
    |-> ##[1:3] o_socket_state == 8'h00) else $error("reset kept open");
  chk_finack_cl: assert property (i_ev_finack &&
    o_socket_state == 8'h18 |-> ##[1:3] o_socket_state == 8'h00)
    else $error("finack kept open");
  chk_conn_fail: assert property ((i_ev_arp_to || i_ev_tcp_to) &&
    o_socket_state == 8'h15 |-> ##[1:3] o_socket_state == 8'h00)
    else $error("timeout kept open");
  chk_con_entry: assert property (o_socket_state == 8'h17 &&
    $past(o_socket_state) != 8'h17 |-> $past(i_ev_synack) ||
    $past(i_ev_synack, 2)) else $error("connected without answer");
endmodule // sci_socket_sva
bind sci_socket sci_socket_sva u_sva (.i_clk, .i_srst, .i_avs_address,
  .i_avs_write, .i_avs_writedata, .o_avs_waitrequest, .i_ev_synack,
  .i_ev_rst, .i_ev_finack, .i_ev_arp_to, .i_ev_tcp_to, .o_tx_fin,
  .o_tx_send, .o_tx_raw_dest, .o_tx_keepalive, .o_rx_consume, .o_ppp_msg,
  .o_ppp_msg_kind, .o_socket_state);
`default_nettype wire

// ### verification/sci_peer_model.sv
/* Packet engine stand-in: answers connect, disconnect and send
   requests after a lag. Assumes the bench's clock. */
`default_nettype none
module sci_peer_model (
  // Clock and behaviour
  input wire logic i_clk,
  input wire logic [3:0] i_lag,
  input wire logic i_mute,
  // Requests
  input wire logic i_tx_syn,
  input wire logic i_tx_fin,
  input wire logic i_tx_send,
  // Answers
  output logic o_ev_synack,
  output logic o_ev_finack,
  output logic o_ev_send_done
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_ev_synack = 1'b0;
    o_ev_finack = 1'b0;
    o_ev_send_done = 1'b0;
  end
  // ----
  // Answers; only the connect answer is silent when muted
  // ----
  always @(posedge i_clk) if (i_tx_syn && !i_mute) begin
    repeat (i_lag) @(posedge i_clk);
    o_ev_synack <= 1'b1;
    @(posedge i_clk);
    o_ev_synack <= 1'b0;
  end
  always @(posedge i_clk) if (i_tx_fin) begin
    repeat (i_lag) @(posedge i_clk);
    o_ev_finack <= 1'b1;
    @(posedge i_clk);
    o_ev_finack <= 1'b0;
  end
  always @(posedge i_clk) if (i_tx_send) begin
    repeat (i_lag) @(posedge i_clk);
    o_ev_send_done <= 1'b1;
    @(posedge i_clk);
    o_ev_send_done <= 1'b0;
  end
endmodule // sci_peer_model
`default_nettype wire

// ### verification/sci_socket_tb.sv
/* Self-checking bench of sci_socket with a packet engine model.
   Assumes the register header on the include path. */
`include "sci_regs.vh"
`default_nettype none
module sci_socket_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, srst = 1'b1, rd = 1'b0, wr = 1'b0, clr = 1'b0;
  logic mute = 1'b0;
  logic [25:0] adr = '0;
  logic [31:0] wdat = '0;
  logic [8:0] tev = '0;
  logic [8:0] seen = '0;
  logic [3:0] lag = 4'h2;
  logic [31:0] rdat;
  logic wrq, syn, fin, snd, raw, ka, cons, lo, lc, msg, irq_n;
  logic synack, finack, sdone;
  logic [1:0] kind;
  logic [15:0] rxptr;
  logic [7:0] st;
  int fail_count = 0;
  int checks_done = 0;
  initial begin
    forever #5 clk = ~clk;
  end
  sci_socket u_dut (.i_clk(clk), .i_srst(srst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wrq), .i_ev_synack(synack),
    .i_ev_rst(tev[0]), .i_ev_fin(tev[1]), .i_ev_finack(finack),
    .i_ev_arp_to(tev[2]), .i_ev_tcp_to(tev[3]), .i_ev_ka_fail(tev[4]),
    .i_ev_data_rx(tev[5]), .i_ev_send_done(sdone), .i_ev_ppp_opt(tev[6]),
    .i_ev_ppp_auth_fail(tev[7]), .i_ev_ppp_phase(tev[8]), .o_tx_syn(syn),
    .o_tx_fin(fin), .o_tx_send(snd), .o_tx_raw_dest(raw),
    .o_tx_keepalive(ka), .o_rx_consume(cons), .o_rx_read_ptr(rxptr),
    .o_ppp_link_open(lo), .o_ppp_link_close(lc), .o_ppp_msg(msg),
    .o_ppp_msg_kind(kind), .o_socket_state(st), .o_net_irq_n(irq_n));
  sci_peer_model u_peer (.i_clk(clk), .i_lag(lag), .i_mute(mute),
    .i_tx_syn(syn), .i_tx_fin(fin), .i_tx_send(snd), .o_ev_synack(synack),
    .o_ev_finack(finack), .o_ev_send_done(sdone));
  // Sticky record of request pulses
  always @(posedge clk)
    seen <= clr ? 9'h000 : seen | {msg, lc, lo, cons, ka, raw, snd, fin, syn};
  // ----
  // Helpers
  // ----
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [23:0] idx, input logic [31:0] d,
    output logic [31:0] q);
    adr <= {idx, 2'b00};
    wr <= w;
    rd <= !w;
    wdat <= d;
    do @(posedge clk); while (wrq !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
    q = rdat;
    @(posedge clk);
  endtask
  task wrr(input logic [23:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask
  task rdc(input logic [23:0] idx, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, idx, 32'h0000_0000, q);
    chk(q, e);
  endtask
  task cmd(input logic [7:0] c);
    clr <= 1'b1;
    wrr(`SCI_IDX_CMD, {24'h00_0000, c});
    clr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task fire(input int n);
    tev[n] <= 1'b1;
    @(posedge clk);
    tev[n] <= 1'b0;
    @(posedge clk);
  endtask
  task wait_st(input logic [7:0] e);
    int n;
    n = 0;
    while (st !== e && n < 80) begin
      @(posedge clk);
      n++;
    end
    chk(32'(st), 32'(e));
  endtask
  task open_in(input logic [31:0] m, input logic [7:0] s);
    wrr(`SCI_IDX_MODE, m);
    cmd(`SCI_CMD_OPEN);
    wait_st(s);
  endtask
  task connect_up;
    open_in(32'h0000_0001, `SCI_ST_INIT);
    cmd(`SCI_CMD_CONNECT);
    wait_st(`SCI_ST_CONNECTED);
  endtask
  // ----
  // Scenarios
  // ----
  task t_regs;
    rdc(`SCI_IDX_FLAGS, 32'h0000_0000);
    rdc(`SCI_IDX_MASK, 32'h0000_00ff);
    wrr(`SCI_IDX_STATE, 32'h0000_0017);
    rdc(`SCI_IDX_STATE, 32'h0000_0000);
    rdc(24'hfe_4ff0, 32'h0000_0000);
  endtask
  task t_conn;
    connect_up;
    rdc(`SCI_IDX_FLAGS, 32'h0000_0001);
    rdc(`SCI_IDX_GFLAGS, 32'h0000_0001);
    chk(32'(irq_n), 32'h0000_0001);
    wrr(`SCI_IDX_GMASK, 32'h0000_0001);
    @(posedge clk);
    chk(32'(irq_n), 32'h0000_0000);
    wrr(`SCI_IDX_FLAGS, 32'h0000_0001);
    rdc(`SCI_IDX_GFLAGS, 32'h0000_0000);
    chk(32'(irq_n), 32'h0000_0001);
  endtask
  task t_data;
    lag <= 4'h6;
    cmd(`SCI_CMD_SEND);
    chk(32'(seen[2]), 32'h0000_0001);
    repeat (8) @(posedge clk);
    rdc(`SCI_IDX_FLAGS, 32'h0000_0010);
    fire(5);
    rdc(`SCI_IDX_FLAGS, 32'h0000_0014);
    wrr(`SCI_IDX_FLAGS, 32'h0000_0010);
    rdc(`SCI_IDX_FLAGS, 32'h0000_0004);
    wrr(`SCI_IDX_RXRD, 32'h0000_1234);
    cmd(`SCI_CMD_RECEIVE_CMD);
    chk(32'(seen[5]), 32'h0000_0001);
    chk(32'(rxptr), 32'h0000_1234);
    wrr(`SCI_IDX_MASK, 32'h0000_00fb);
    wrr(`SCI_IDX_FLAGS, 32'h0000_0004);
    fire(5);
    rdc(`SCI_IDX_FLAGS, 32'h0000_0000);
    wrr(`SCI_IDX_MASK, 32'h0000_00ff);
    lag <= 4'h1;
  endtask
  task t_disconnect_cmd;
    cmd(`SCI_CMD_DISCONNECT_CMD);
    chk(32'(seen[1]), 32'h0000_0001);
    wait_st(`SCI_ST_CLOSED);
    rdc(`SCI_IDX_FLAGS, 32'h0000_0002);
    wrr(`SCI_IDX_FLAGS, 32'h0000_00ff);
  endtask
  task t_peer;
    connect_up;
    fire(1);
    rdc(`SCI_IDX_FLAGS, 32'h0000_0003);
    wrr(`SCI_IDX_FLAGS, 32'h0000_00ff);
    fire(0);
    wait_st(`SCI_ST_CLOSED);
    connect_up;
    cmd(`SCI_CMD_KEEP);
    chk(32'(seen[4]), 32'h0000_0001);
    fire(4);
    rdc(`SCI_IDX_FLAGS, 32'h0000_0009);
    wrr(`SCI_IDX_FLAGS, 32'h0000_00ff);
    cmd(`SCI_CMD_CLOSE);
    chk(32'(seen[1]), 32'h0000_0000);
    wait_st(`SCI_ST_CLOSED);
  endtask
  task t_fail;
    int evs[3] = '{2, 3, 0};
    logic [31:0] fl[3] = '{32'h0000_0008, 32'h0000_0008, 32'h0000_0000};
    mute <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      open_in(32'h0000_0001, `SCI_ST_INIT);
      cmd(`SCI_CMD_CONNECT);
      wait_st(`SCI_ST_SYNSENT);
      fire(evs[i]);
      wait_st(`SCI_ST_CLOSED);
      rdc(`SCI_IDX_FLAGS, fl[i]);
      wrr(`SCI_IDX_FLAGS, 32'h0000_00ff);
    end
    open_in(32'h0000_0001, `SCI_ST_INIT);
    cmd(`SCI_CMD_LISTEN);
    wait_st(`SCI_ST_LISTEN);
    fire(3);
    wait_st(`SCI_ST_CLOSED);
    wrr(`SCI_IDX_FLAGS, 32'h0000_00ff);
    mute <= 1'b0;
  endtask
  task t_udp;
    open_in(32'h0000_0002, `SCI_ST_UDP);
    cmd(`SCI_CMD_SEND_RAW);
    chk(32'(seen[3:2]), 32'h0000_0003);
    repeat (4) @(posedge clk);
    rdc(`SCI_IDX_FLAGS, 32'h0000_0010);
    wrr(`SCI_IDX_FLAGS, 32'h0000_00ff);
    cmd(`SCI_CMD_PREQ);
    chk(32'(seen), 32'h0000_0000);
    cmd(`SCI_CMD_CLOSE);
  endtask
  task t_ppp;
    logic [7:0] codes[5] = '{8'h23, 8'h25, 8'h26, 8'h27, 8'h24};
    logic [8:0] want[5] = '{9'h040, 9'h100, 9'h100, 9'h100, 9'h080};
    open_in(32'h0000_0005, `SCI_ST_PPPOE);
    fire(8);
    fire(7);
    fire(6);
    rdc(`SCI_IDX_FLAGS, 32'h0000_00e0);
    wrr(`SCI_IDX_FLAGS, 32'h0000_00ff);
    for (int i = 0; i < 5; i++) begin
      cmd(codes[i]);
      chk(32'(seen), 32'(want[i]));
      if (i > 0 && i < 4) chk(32'(kind), 32'(i - 1));
    end
  endtask
  task give_verdict;
    if (fail_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_conn;
    t_data;
    t_disconnect_cmd;
    t_peer;
    t_fail;
    t_udp;
    t_ppp;
    give_verdict;
  end
  initial begin
    #300000;
    fail_count++;
    give_verdict;
  end
endmodule // sci_socket_tb
`default_nettype wire
